// file: core/gpx_edge.sv
`timescale 1ns/1ps
// Finds serial clock edges and start and stop conditions on synchronised lines.
module gpx_edge
  import gpx_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rstn,
  // Synchronised bus lines.
  input  wire logic scl_s,
  input  wire logic sda_s,
  // One-cycle events.
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  logic scl_q_r;
  logic sda_q_r;

  // Previous samples, reset to the idle high level so reset makes no event.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // A data change while the clock stays high is a start or a stop.
  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

endmodule

// file: core/gpx_pkg.sv
// Overview of operation
// - Sixteen pins in two byte ports, each pin's direction set on its own.
// - After power-up every pin is an input before any host access.
// - Each port has four byte registers; bit n belongs to pin n.
// - Pointer 0 to 7 selects level, drive, invert, direction pairs with fixed resets.
// - Both pin level registers hold all ones until a level is captured.
// - Pin level registers report the real pin level in either direction.
// - Writes to pin level registers are acknowledged but change nothing.
// - A drive value bit acts only on a pin set as output.
// - Reading a drive value register returns the stored bits, not the pins.
// - An invert bit of one flips the reported level bit; zero keeps it.
// - Direction bit one makes a floating input, zero makes an output.
// - An output pin is driven high or low from its drive value bit.
// - An input pin has both drivers switched off.
// - The interrupt output is open drain and pulls low when active.
// - A low level on the reset input reinitialises the logic.
// - In a write the byte after the address is the pointer, then data follows.
// - After each data byte the pointer swaps to the other port's same register.
// - Written drive values reach the pins at the acknowledge's rising clock edge.
// - Reading a level register captures only that port's pins at the acknowledge, clearing that port's share of the interrupt.
package gpx_pkg;

  // Register pointer values.
  localparam logic [2:0] PTR_LEVEL0  = 3'h0;
  localparam logic [2:0] PTR_LEVEL1  = 3'h1;
  localparam logic [2:0] PTR_DRIVE0  = 3'h2;
  localparam logic [2:0] PTR_DRIVE1  = 3'h3;
  localparam logic [2:0] PTR_INVERT0 = 3'h4;
  localparam logic [2:0] PTR_INVERT1 = 3'h5;
  localparam logic [2:0] PTR_DIR0    = 3'h6;
  localparam logic [2:0] PTR_DIR1    = 3'h7;
  localparam logic [2:0] PTR_RST     = 3'h0;

  // Register type field, the pointer without its port bit.
  localparam logic [1:0] TYPE_LEVEL  = 2'h0;
  localparam logic [1:0] TYPE_DRIVE  = 2'h1;
  localparam logic [1:0] TYPE_INVERT = 2'h2;
  localparam logic [1:0] TYPE_DIR    = 2'h3;

  // Values after reset, per port byte.
  localparam logic [7:0] LEVEL_RST  = 8'hff;
  localparam logic [7:0] DRIVE_RST  = 8'hff;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hff;

  // Fixed upper bits of the seven-bit slave address; low three come from straps.
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // Clock figures; the serial clock must be sampled several times per period.
  localparam int CORE_CLK_HZ   = 25_000_000;
  localparam int SCL_MAX_HZ    = 1_000_000;
  localparam int SCL_HS_MAX_HZ = 2_000_000;
  localparam int SCL_MIN_CLKS  = CORE_CLK_HZ / SCL_HS_MAX_HZ;

  // Serial protocol states.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR      = 4'h3,
    ST_ACK_PTR  = 4'h4,
    ST_WR       = 4'h5,
    ST_ACK_WR   = 4'h6,
    ST_RD       = 4'h7,
    ST_ACK_RD   = 4'h8
  } gpx_state_t;

endpackage

// file: core/gpx_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of asynchronous inputs.
module gpx_sync
  import gpx_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second; reset to ones like idle pulled-up lines.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: core/gpx_top.sv
`timescale 1ns/1ps
// Sixteen-bit port expander behind a two-wire serial slave.
module gpx_top
  import gpx_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Serial bus: clock in, data as open drain.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Address straps.
  input  wire logic        slave_select_pin_0,
  input  wire logic        slave_select_pin_1,
  input  wire logic        slave_select_pin_2,
  // Port 0 pins.
  input  wire logic [7:0]  port0_pins_in,
  output logic      [7:0]  port0_pins_out,
  output logic      [7:0]  port0_pins_oe_n,
  // Port 1 pins.
  input  wire logic [7:0]  port1_pins_in,
  output logic      [7:0]  port1_pins_out,
  output logic      [7:0]  port1_pins_oe_n,
  // Interrupt, open drain.
  output logic             int_out,
  output logic             int_oe_n
);

  // Synchronised inputs.
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  sel_s;
  logic [15:0] pins_s;

  // Bus events.
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  // Protocol state.
  gpx_state_t  state_r;
  gpx_state_t  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        rw_r;
  logic        rw_nxt;
  logic        mack_r;
  logic        mack_nxt;
  logic        sda_oe_n_nxt;

  // Register file, port 1 in the upper byte of each vector.
  logic [2:0]  ptr_r;
  logic [15:0] level_r;
  logic [15:0] drive_r;
  logic [15:0] invert_r;
  logic [15:0] dir_r;

  // Every asynchronous input passes two flip-flops first. The straps go through
  // the same stages; they are meant to be static, so the lag costs nothing.
  // The bundle is two bus lines, three straps and sixteen pins, 21 bits in all.
  gpx_sync #(
    .W (21)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({scl_in, sda_in, slave_select_pin_2, slave_select_pin_1,
                slave_select_pin_0, port1_pins_in, port0_pins_in}),
    .sync_out ({scl_s, sda_s, sel_s, pins_s})
  );

  // Edge and condition detection on the synchronised lines.
  gpx_edge u_edge (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // Picks one byte of a two-port vector by the pointer's port bit.
  function automatic logic [7:0] port_byte(input logic [15:0] v, input logic port);
    port_byte = port ? v[15:8] : v[7:0];
  endfunction

  // Replaces one port byte of a vector, leaving the other port untouched.
  function automatic logic [15:0] put_byte(input logic [15:0] v, input logic port,
                                           input logic [7:0] b);
    put_byte = port ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  // Register read selection; level bytes are shown through the invert mask.
  function automatic logic [7:0] reg_read(input logic [2:0] p, input logic [15:0] lvl,
                                          input logic [15:0] drv, input logic [15:0] inv,
                                          input logic [15:0] dir);
    logic [7:0] r;
    r = 8'h00;
    unique case (p[2:1])
      TYPE_LEVEL:  r = port_byte(lvl, p[0]) ^ port_byte(inv, p[0]);
      TYPE_DRIVE:  r = port_byte(drv, p[0]);
      TYPE_INVERT: r = port_byte(inv, p[0]);
      TYPE_DIR:    r = port_byte(dir, p[0]);
    endcase
    reg_read = r;
  endfunction

  // Decoded strobes and selections.
  logic [7:0]  rd_byte;
  logic        addr_hit;
  logic        in_ack_wr;
  logic        in_ack_rd;
  logic        wr_en;
  logic        wr_drive;
  logic        wr_invert;
  logic        wr_dir;
  logic        ptr_load;
  logic        ptr_swap;
  logic        cap_en;
  logic        int_pend;

  assign rd_byte   = reg_read(ptr_r, level_r, drive_r, invert_r, dir_r);
  assign addr_hit  = (shift_r[7:1] == {ADDR_FIXED, sel_s});
  assign in_ack_wr = (state_r == ST_ACK_WR);
  assign in_ack_rd = (state_r == ST_ACK_RD);

  // Data is committed on the rising clock edge inside its acknowledge slot.
  assign wr_en     = scl_rise & in_ack_wr;
  assign wr_drive  = wr_en & (ptr_r[2:1] == TYPE_DRIVE);
  assign wr_invert = wr_en & (ptr_r[2:1] == TYPE_INVERT);
  assign wr_dir    = wr_en & (ptr_r[2:1] == TYPE_DIR);
  // Level type writes select no strobe at all, so they are dropped after the ack.
  assign ptr_load  = scl_rise & (state_r == ST_ACK_PTR);
  assign ptr_swap  = scl_rise & (in_ack_wr | in_ack_rd);
  assign cap_en    = scl_rise & in_ack_rd & (ptr_r[2:1] == TYPE_LEVEL);

  // Only pins set as inputs may raise the interrupt; a changed drive value on an output pin never does.
  assign int_pend  = |((pins_s ^ level_r) & dir_r);

  // Next-state logic of the serial slave. A stop or a new start overrides any
  // state, so a host that aborts mid-byte never leaves the data line held low.
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    shift_nxt    = shift_r;
    rw_nxt       = rw_r;
    mack_nxt     = mack_r;
    sda_oe_n_nxt = sda_oe_n;
    if (stop_det) begin
      state_nxt    = ST_IDLE;
      sda_oe_n_nxt = 1'b1;
    end else if (start_det) begin
      state_nxt    = ST_ADDR;
      cnt_nxt      = 4'h0;
      sda_oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          cnt_nxt = 4'h0;
        end
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && (cnt_r == BYTE_BITS)) begin
            cnt_nxt = 4'h0;
            if (state_r == ST_ADDR) begin
              if (addr_hit) begin
                state_nxt    = ST_ACK_ADDR;
                rw_nxt       = shift_r[0];
                sda_oe_n_nxt = 1'b0;
              end else begin
                state_nxt = ST_IDLE;
              end
            end else if (state_r == ST_PTR) begin
              state_nxt    = ST_ACK_PTR;
              sda_oe_n_nxt = 1'b0;
            end else begin
              // Writes to level registers are acknowledged like any other.
              state_nxt    = ST_ACK_WR;
              sda_oe_n_nxt = 1'b0;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_r) begin
              state_nxt    = ST_RD;
              shift_nxt    = rd_byte;
              sda_oe_n_nxt = rd_byte[7];
            end else begin
              state_nxt    = ST_PTR;
              sda_oe_n_nxt = 1'b1;
            end
          end
        end
        ST_ACK_PTR, ST_ACK_WR: begin
          if (scl_fall) begin
            state_nxt    = ST_WR;
            sda_oe_n_nxt = 1'b1;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              cnt_nxt      = 4'h0;
              state_nxt    = ST_ACK_RD;
              sda_oe_n_nxt = 1'b1;
            end else begin
              shift_nxt    = {shift_r[6:0], 1'b1};
              sda_oe_n_nxt = shift_r[6];
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise) begin
            mack_nxt = ~sda_s;
          end else if (scl_fall) begin
            // The pointer has already swapped, so the next byte is the other port.
            if (mack_r) begin
              state_nxt    = ST_RD;
              shift_nxt    = rd_byte;
              sda_oe_n_nxt = rd_byte[7];
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Protocol registers.
  // The reset is synchronous, so it needs a running clock to take effect.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      rw_r     <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      shift_r  <= shift_nxt;
      rw_r     <= rw_nxt;
      mack_r   <= mack_nxt;
      sda_oe_n <= sda_oe_n_nxt;
    end
  end

  // Pointer: loaded from the pointer byte, then swapped port after each data byte.
  // Only the low three bits of the pointer byte are kept; the rest is ignored.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ptr_r <= PTR_RST;
    end else if (ptr_load) begin
      ptr_r <= shift_r[2:0];
    end else if (ptr_swap) begin
      ptr_r <= ptr_r ^ 3'h1;
    end
  end

  // Configuration registers; one port byte changes per data byte.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drive_r  <= {DRIVE_RST, DRIVE_RST};
      invert_r <= {INVERT_RST, INVERT_RST};
      dir_r    <= {DIR_RST, DIR_RST};
    end else begin
      if (wr_drive) begin
        drive_r <= put_byte(drive_r, ptr_r[0], shift_r);
      end
      if (wr_invert) begin
        invert_r <= put_byte(invert_r, ptr_r[0], shift_r);
      end
      if (wr_dir) begin
        dir_r <= put_byte(dir_r, ptr_r[0], shift_r);
      end
    end
  end

  // Captured pin levels. The capture takes the real pin whatever its direction,
  // and only during a read acknowledge, so the value a host sees is stable.
  // Only the port being read is captured; the other byte keeps its old value.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      level_r <= {LEVEL_RST, LEVEL_RST};
    end else if (cap_en) begin
      level_r <= put_byte(level_r, ptr_r[0], port_byte(pins_s, ptr_r[0]));
    end
  end

  // Pin drivers. A set direction bit turns both drivers off; a clear one drives
  // the stored value. The drive value stays stored while the pin is an input.
  // Registering both keeps the pin drivers free of glitches when a byte lands.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port0_pins_out  <= DRIVE_RST;
      port1_pins_out  <= DRIVE_RST;
      port0_pins_oe_n <= DIR_RST;
      port1_pins_oe_n <= DIR_RST;
    end else begin
      port0_pins_out  <= drive_r[7:0];
      port1_pins_out  <= drive_r[15:8];
      port0_pins_oe_n <= dir_r[7:0];
      port1_pins_oe_n <= dir_r[15:8];
    end
  end

  // Interrupt as open drain: the driven level is always low, only the enable moves.
  // It clears by itself once the captured level matches the pins again.
  // Being level based, a pin that returns to its captured level clears it too.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      int_out  <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      int_out  <= 1'b0;
      int_oe_n <= ~int_pend;
    end
  end

  // The data line is open drain too; only its enable carries information.
  // Keeping it a flip-flop lets every top output come straight from a register.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

endmodule

// file: sim/gpx_host.sv
`timescale 1ns/1ps
// Behavioural two-wire bus host; its lines move only on core_clk falling edges.
module gpx_host (
  // Pacing clock.
  input  wire logic core_clk,
  // Device data drive, low pulls the shared line.
  input  wire logic sda_oe_n,
  // Host lines, idle high.
  output logic      scl,
  output logic      sda
);
  logic line;

  // The pull-up resolves the shared data wire.
  assign line = sda & sda_oe_n;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Data moves a cycle after the fall so no edge looks like a start or stop.
  task automatic bit_io(input logic b, output logic r);
    gap(1);
    sda = b;
    gap(3);
    // The clock period is fixed by this pacing, eight core cycles a bit.
    scl = 1'b1;
    gap(2);
    r = line;
    gap(2);
    scl = 1'b0;
  endtask

  task automatic start_c();
    gap(1);
    sda = 1'b1;
    gap(2);
    scl = 1'b1;
    gap(4);
    sda = 1'b0;
    gap(4);
    scl = 1'b0;
  endtask

  // The clock is left high afterwards, standing still between frames.
  task automatic stop_c();
    gap(1);
    sda = 1'b0;
    gap(3);
    scl = 1'b1;
    gap(4);
    sda = 1'b1;
    gap(4);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Address, pointer, then n data bytes low byte first; stops at a refusal.
  task automatic xfer_w(input logic [6:0] adr, input logic [7:0] ptr,
                        input logic [15:0] d, input int n, output logic ok);
    logic a;
    start_c();
    send({adr, 1'b0}, ok);
    if (ok) begin
      send(ptr, a);
      ok = a;
    end
    for (int k = 0; k < n && ok; k++) begin
      send(d[8*k +: 8], a);
      ok = a;
    end
    stop_c();
  endtask

  // Reads n bytes, acknowledging all but the last.
  task automatic xfer_r(input logic [6:0] adr, input int n, output logic [15:0] q);
    logic a;
    logic r;
    q = 16'h0000;
    start_c();
    send({adr, 1'b1}, a);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        q[8*k+i] = r;
      end
      bit_io(k == n - 1, r);
    end
    stop_c();
  endtask
endmodule

// file: sim/gpx_top_assertions.sv
`timescale 1ns/1ps
// Port-level checks of bus, pin and interrupt timing for the expander.
module gpx_top_assertions
  import gpx_pkg::*;
(
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rstn,
  // Serial bus.
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Port pins.
  input wire logic [7:0] port0_pins_in,
  input wire logic [7:0] port0_pins_out,
  input wire logic [7:0] port0_pins_oe_n,
  input wire logic [7:0] port1_pins_in,
  input wire logic [7:0] port1_pins_out,
  input wire logic [7:0] port1_pins_oe_n,
  // Interrupt.
  input wire logic       int_out,
  input wire logic       int_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [3:0] quiet_r;

  // Counts cycles with no activity that could move the interrupt; saturates.
  always_ff @(posedge core_clk) begin
    if (!rstn || $changed({scl_in, sda_in, port0_pins_in, port1_pins_in,
                           port0_pins_oe_n, port1_pins_oe_n})) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  // The clock has been high for three samples, well clear of the sync lag.
  sequence scl_held;
    scl_in && $past(scl_in) && $past(scl_in, 2);
  endsequence

  // A pin drive or direction changed outside a reset.
  sequence pins_moved;
    $past(rstn) && $changed({port0_pins_out, port1_pins_out,
                             port0_pins_oe_n, port1_pins_oe_n});
  endsequence

  rst_pins_a: assert property (disable iff (1'b0) !rstn |=>
    {port0_pins_oe_n, port1_pins_oe_n, port0_pins_out, port1_pins_out} == {4{8'hff}})
    else $error("Pins not returned to inputs by reset.");
  rst_bus_a: assert property (disable iff (1'b0) !rstn |=> sda_oe_n && int_oe_n)
    else $error("Bus or interrupt driven during reset.");
  wake_quiet_a: assert property ($rose(rstn) |-> sda_oe_n [*4])
    else $error("Data line driven right after reset.");
  int_drain_a: assert property (int_out == 1'b0)
    else $error("Interrupt output drives high.");
  sda_drain_a: assert property (sda_out == 1'b0)
    else $error("Data output drives high.");
  pin_at_ack_a: assert property (pins_moved |-> !sda_oe_n)
    else $error("Pins changed outside a data acknowledge.");
  sda_hold_a: assert property (scl_held |-> $stable(sda_oe_n))
    else $error("Data line moved while clock high.");
  sda_setup_a: assert property ($past(rstn) && $changed(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("Data line moved too late in the low phase.");
  int_steady_a: assert property (quiet_r >= 4'h6 |-> $stable(int_oe_n))
    else $error("Interrupt moved with no cause.");
endmodule

bind gpx_top gpx_top_assertions chk (.core_clk, .rstn, .scl_in, .sda_in, .sda_out,
  .sda_oe_n, .port0_pins_in, .port0_pins_out, .port0_pins_oe_n, .port1_pins_in,
  .port1_pins_out, .port1_pins_oe_n, .int_out, .int_oe_n);

// file: sim/gpx_top_tb.sv
`timescale 1ns/1ps
// Register and pin tests for the expander, driven through the bus host model.
module gpx_top_tb;
  import gpx_pkg::*;
  localparam logic [6:0] ADR = {ADDR_FIXED, 3'h5};
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       scl_in, sda_in, sda_out, sda_oe_n, int_out, int_oe_n, sda_h, ok;
  logic [7:0] port0_pins_in, port0_pins_out, port0_pins_oe_n;
  logic [7:0] port1_pins_in, port1_pins_out, port1_pins_oe_n;
  logic [7:0] ext0 = 8'hff;
  logic [7:0] ext1 = 8'hff;
  logic [15:0] q;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  initial forever #20 core_clk = ~core_clk;

  // Driven pins show their drive value; undriven ones the outside level.
  assign sda_in = sda_h & sda_oe_n;
  assign port0_pins_in = (~port0_pins_oe_n & port0_pins_out) | (port0_pins_oe_n & ext0);
  assign port1_pins_in = (~port1_pins_oe_n & port1_pins_out) | (port1_pins_oe_n & ext1);

  gpx_top dut (.core_clk, .rstn, .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .slave_select_pin_0(1'b1), .slave_select_pin_1(1'b0), .slave_select_pin_2(1'b1),
    .port0_pins_in, .port0_pins_out, .port0_pins_oe_n, .port1_pins_in,
    .port1_pins_out, .port1_pins_oe_n, .int_out, .int_oe_n);
  gpx_host host (.core_clk, .sda_oe_n, .scl(scl_in), .sda(sda_h));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    host.xfer_w(ADR, ptr, d, 2, ok);
    check({15'h0, ok}, 16'h0001);
  endtask

  // Pointer set by an empty write, then two bytes read back.
  task automatic rd(input logic [7:0] ptr);
    host.xfer_w(ADR, ptr, 16'h0000, 0, ok);
    host.xfer_r(ADR, 2, q);
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    check({port1_pins_oe_n, port0_pins_oe_n}, 16'hffff);
    check({port1_pins_out, port0_pins_out}, 16'hffff);
    ext0 = 8'h3c;
    repeat (10) @(negedge core_clk);
    check({15'h0, int_oe_n}, 16'h0000);
    rd(PTR_LEVEL0);
    check(q, {2{LEVEL_RST}});
    check({15'h0, int_oe_n}, 16'h0001);
    rd(PTR_LEVEL0);
    check(q, 16'hff3c);
    for (int i = 1; i < 4; i++) begin
      rd(8'(2 * i));
      check(q, (i == 1) ? {2{DRIVE_RST}} : (i == 2) ? {2{INVERT_RST}} : {2{DIR_RST}});
    end
    // Drive values land but pins stay undriven while inputs.
    wr(PTR_DRIVE0, 16'h5aa5);
    check({port1_pins_out, port0_pins_out}, 16'h5aa5);
    check({port1_pins_oe_n, port0_pins_oe_n}, 16'hffff);
    wr(PTR_DIR0, 16'h0ff0);
    check({port1_pins_oe_n, port0_pins_oe_n}, 16'h0ff0);
    ext0 = 8'h3c;
    ext1 = 8'hc3;
    rd(PTR_DRIVE0);
    check(q, 16'h5aa5);
    wr(PTR_INVERT0, 16'hf00f);
    rd(PTR_LEVEL0);
    rd(PTR_LEVEL0);
    check(q, {8'h53 ^ 8'hf0, 8'h35 ^ 8'h0f});
    // Writes to the level pair change nothing.
    wr(PTR_LEVEL0, 16'h0000);
    check({port1_pins_out, port0_pins_out}, 16'h5aa5);
    rd(PTR_LEVEL0);
    check(q, 16'ha33a);
    host.xfer_w(ADR ^ 7'h01, PTR_DRIVE0, 16'h0000, 2, ok);
    check({15'h0, ok}, 16'h0000);
    check({port1_pins_out, port0_pins_out}, 16'h5aa5);
    wr(PTR_DIR0, 16'hffff);
    check({port1_pins_oe_n, port0_pins_oe_n}, 16'hffff);
    wr(PTR_DIR0, 16'h00ff);
    // A reset in mid-run returns the direction, level and invert registers and the pointer.
    rstn = 1'b0;
    repeat (3) @(negedge core_clk);
    check({port1_pins_oe_n, port0_pins_oe_n}, 16'hffff);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    host.xfer_r(ADR, 2, q);
    check(q, {2{LEVEL_RST}});
    close_out();
  end
endmodule
